// ---- hdl/fpc_pkg.sv ----
// constants and code tables shared by the coding path
package fpc_pkg;
	// ****************************************
	// rates and widths
	// ****************************************
	localparam int LINE_RATE_MHZ = 125; // one line bit per clock at this rate
	localparam int REF_CLK_MHZ = 10; // bench rate of the same clock
	localparam int LFSR_W = 11;
	localparam logic [10:0] LFSR_SEED = 11'h7FF;
	localparam int LFSR_TAP_A = 10;
	localparam int LFSR_TAP_B = 8;
	localparam int FIFO_W = 6;
	localparam int FIFO_D = 4;
	localparam logic [2:0] GRP_LAST = 3'h4; // last bit index of a code group
	localparam logic [6:0] LOCK_MATCHES = 7'h3C; // idle bits to trust descrambler
	localparam logic [6:0] QUIET_MAX = 7'h7F; // bits without transition = no signal

	// ****************************************
	// code groups, sent msb first
	// ****************************************
	localparam logic [4:0] SYM_IDLE = 5'h1F;
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0D;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_H = 5'h04;
	localparam logic [9:0] SYM_JK = 10'h311;
	localparam logic [3:0] NIB_PREAMBLE = 4'h5;

	// mlt3 phases: zero, plus, zero, minus
	localparam logic [1:0] MLT_PLUS = 2'h1;
	localparam logic [1:0] MLT_MINUS = 2'h3;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_SSD = 4'h2,
		TX_DATA = 4'h4,
		TX_ESD = 4'h8
	} fpc_tx_e;

	// nibble to data code group
	function automatic logic [4:0] enc4b5b(input logic [3:0] n);
		logic [4:0] c;
		c = 5'h1E;
		case (n)
			4'h0: c = 5'h1E;
			4'h1: c = 5'h09;
			4'h2: c = 5'h14;
			4'h3: c = 5'h15;
			4'h4: c = 5'h0A;
			4'h5: c = 5'h0B;
			4'h6: c = 5'h0E;
			4'h7: c = 5'h0F;
			4'h8: c = 5'h12;
			4'h9: c = 5'h13;
			4'hA: c = 5'h16;
			4'hB: c = 5'h17;
			4'hC: c = 5'h1A;
			4'hD: c = 5'h1B;
			4'hE: c = 5'h1C;
			default: c = 5'h1D;
		endcase
		return c;
	endfunction

	// data code group to {hit, nibble}; hit low for control or invalid groups
	function automatic logic [4:0] dec5b4b(input logic [4:0] c);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (enc4b5b(4'(i)) == c) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction
endpackage

// ---- hdl/fpc_fifo.sv ----
// small synchronous fifo between the mac nibble port and the transmit coder
`timescale 1ns/10ps
module fpc_fifo #(
	parameter int W = 6,
	parameter int D = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] cnt_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// full and empty come straight from the count
	assign in_ready = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_ptr_r];

	// storage has no reset, only pointers and count do
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + AW'(push);
			rd_ptr_r <= rd_ptr_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_count_step: assert property (@(posedge clk) disable iff (!rst_n)
		(push && !pop) |=> cnt_r == $past(cnt_r) + (AW+1)'(1))
		else $error("fifo count did not follow a push");
endmodule

// ---- hdl/fpc_lfsr.sv ----
// 11-bit scrambler key generator, free running or loaded from the line
`timescale 1ns/10ps
module fpc_lfsr (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load_en,
	input wire logic load_bit,
	output logic key
);
	logic [fpc_pkg::LFSR_W-1:0] lfsr_r;

	// x^11 + x^9 + 1, maximal length so the key repeats every 2047 bits
	assign key = lfsr_r[fpc_pkg::LFSR_TAP_A] ^ lfsr_r[fpc_pkg::LFSR_TAP_B];

	// loading the received bit makes a receiver follow the far transmitter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_r <= fpc_pkg::LFSR_SEED;
		end else begin
			lfsr_r <= {lfsr_r[fpc_pkg::LFSR_W-2:0], load_en ? load_bit : key};
		end
	end

	a_lfsr_feedback: assert property (@(posedge clk) disable iff (!rst_n)
		!load_en |=> lfsr_r[0] == $past(lfsr_r[10] ^ lfsr_r[8]) &&
			lfsr_r[10:1] == $past(lfsr_r[9:0]))
		else $error("lfsr did not advance by its polynomial");
endmodule

// ---- hdl/fpc_top.sv ----
// 100 and 10 Mbit/s coding path, scrambler only at 100: nibbles to mlt3 symbols and back
`timescale 1ns/10ps
module fpc_top (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic SPEED_100,
	input wire logic [3:0] TXD,
	input wire logic TX_EN,
	input wire logic TX_ER,
	output logic TX_READY,
	output logic TX_MLT3_P,
	output logic TX_MLT3_N,
	input wire logic RX_MLT3_P,
	input wire logic RX_MLT3_N,
	output logic [3:0] RXD,
	output logic RX_DV,
	output logic RX_ER,
	output logic RX_VALID,
	output logic RX_LOCKED
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic spd_s1_r, spd_s2_r, rxp_s1_r, rxp_s2_r, rxn_s1_r, rxn_s2_r;

	// line and strap pins come from outside the clock domain
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			{spd_s1_r, spd_s2_r} <= 2'h0;
			{rxp_s1_r, rxp_s2_r, rxn_s1_r, rxn_s2_r} <= 4'h0;
		end else begin
			{spd_s1_r, spd_s2_r} <= {SPEED_100, spd_s1_r};
			{rxp_s1_r, rxp_s2_r} <= {RX_MLT3_P, rxp_s1_r};
			{rxn_s1_r, rxn_s2_r} <= {RX_MLT3_N, rxn_s1_r};
		end
	end
	wire fast = spd_s2_r;

	// ****************************************
	// transmit: fifo and group sequencer
	// ****************************************
	logic fifo_valid;
	logic [5:0] fifo_data;
	logic [2:0] tx_bit_r;
	logic [4:0] tx_sh_r;
	fpc_pkg::fpc_tx_e tx_st_r, tx_st_nxt;
	logic [4:0] tx_grp_nxt;
	logic tx_take;
	logic tx_pop;

	fpc_fifo #(.W(fpc_pkg::FIFO_W), .D(fpc_pkg::FIFO_D)) u_txq (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.in_valid(TX_EN || TX_ER),
		.in_ready(TX_READY),
		.in_data({TX_EN, TX_ER, TXD}),
		.out_valid(fifo_valid),
		.out_ready(tx_pop),
		.out_data(fifo_data)
	);

	wire q_en = fifo_valid && fifo_data[5];
	wire tx_bound = (tx_bit_r == fpc_pkg::GRP_LAST);
	assign tx_pop = tx_bound && tx_take;
	wire [4:0] q_code = fifo_data[4] ? fpc_pkg::SYM_H : fpc_pkg::enc4b5b(fifo_data[3:0]);

	// next code group at each group boundary; preamble start becomes J K
	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_grp_nxt = fpc_pkg::SYM_IDLE;
		tx_take = 1'b0;
		case (tx_st_r)
			fpc_pkg::TX_IDLE: begin
				tx_take = fifo_valid;
				if (q_en) begin
					tx_grp_nxt = fpc_pkg::SYM_J;
					tx_st_nxt = fpc_pkg::TX_SSD;
				end
			end
			fpc_pkg::TX_SSD: begin
				tx_take = q_en;
				tx_grp_nxt = fpc_pkg::SYM_K;
				tx_st_nxt = fpc_pkg::TX_DATA;
			end
			fpc_pkg::TX_DATA: begin
				tx_take = fifo_valid;
				if (q_en) begin
					tx_grp_nxt = q_code;
				end else begin
					tx_grp_nxt = fpc_pkg::SYM_T; // an underrun also closes the frame
					tx_st_nxt = fpc_pkg::TX_ESD;
				end
			end
			fpc_pkg::TX_ESD: begin
				tx_grp_nxt = fpc_pkg::SYM_R;
				tx_st_nxt = fpc_pkg::TX_IDLE;
			end
			default: begin
				tx_st_nxt = fpc_pkg::TX_IDLE;
			end
		endcase
	end

	// five line bits per nibble; the mac is paced by the fifo ready
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			tx_bit_r <= 3'h0;
			tx_sh_r <= fpc_pkg::SYM_IDLE;
			tx_st_r <= fpc_pkg::TX_IDLE;
		end else if (tx_bound) begin
			tx_bit_r <= 3'h0;
			tx_sh_r <= tx_grp_nxt;
			tx_st_r <= tx_st_nxt;
		end else begin
			tx_bit_r <= tx_bit_r + 3'h1;
			tx_sh_r <= {tx_sh_r[3:0], 1'b1};
		end
	end

	// ****************************************
	// transmit: scrambler, nrzi, mlt3
	// ****************************************
	logic tx_key, tx_nrzi_r, tx_nrzi_d_r, tx_p_r, tx_n_r;
	logic [1:0] tx_mlt_r;

	fpc_lfsr u_tx_scr (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.load_en(1'b0),
		.load_bit(1'b0),
		.key(tx_key)
	);

	wire tx_code_bit = tx_sh_r[4];
	wire tx_scr_bit = tx_code_bit ^ (fast & tx_key);
	wire tx_step = tx_nrzi_r ^ tx_nrzi_d_r;
	wire [1:0] tx_mlt_nxt = tx_mlt_r + {1'b0, tx_step};

	// mlt3 moves one phase on each nrzi transition, holds otherwise
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			{tx_nrzi_r, tx_nrzi_d_r} <= 2'h0;
			tx_mlt_r <= 2'h0;
			{tx_p_r, tx_n_r} <= 2'h0;
		end else begin
			tx_nrzi_r <= tx_nrzi_r ^ tx_scr_bit;
			tx_nrzi_d_r <= tx_nrzi_r;
			tx_mlt_r <= tx_mlt_nxt;
			tx_p_r <= (tx_mlt_nxt == fpc_pkg::MLT_PLUS);
			tx_n_r <= (tx_mlt_nxt == fpc_pkg::MLT_MINUS);
		end
	end
	assign TX_MLT3_P = tx_p_r;
	assign TX_MLT3_N = tx_n_r;

	// ****************************************
	// receive: mlt3 to nrzi to nrz
	// ****************************************
	logic [1:0] rx_lvl_d_r;
	logic rx_nrzi_r, rx_nrzi_d_r, rx_act_r;
	logic [6:0] rx_quiet_r;
	wire [1:0] rx_lvl = {rxp_s2_r, rxn_s2_r};
	wire rx_chg = (rx_lvl != rx_lvl_d_r);
	wire rx_nrz = rx_nrzi_r ^ rx_nrzi_d_r;

	// activity stands for recovered timing; long silence drops it
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_lvl_d_r <= 2'h0;
			{rx_nrzi_r, rx_nrzi_d_r, rx_act_r} <= 3'h0;
			rx_quiet_r <= 7'h0;
		end else begin
			rx_lvl_d_r <= rx_lvl;
			rx_nrzi_r <= rx_nrzi_r ^ rx_chg;
			rx_nrzi_d_r <= rx_nrzi_r;
			rx_quiet_r <= rx_chg ? 7'h0 : rx_quiet_r + 7'(rx_quiet_r != fpc_pkg::QUIET_MAX);
			rx_act_r <= rx_chg || (rx_act_r && rx_quiet_r != fpc_pkg::QUIET_MAX);
		end
	end

	// ****************************************
	// receive: descrambler and lock
	// ****************************************
	logic rx_key, rx_lock_r;
	logic [6:0] rx_match_r;

	// while unlocked each line bit is taken as scrambled idle, so its inverse is the key
	fpc_lfsr u_rx_scr (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.load_en(!rx_lock_r),
		.load_bit(!rx_nrz),
		.key(rx_key)
	);

	wire rx_desc = rx_nrz ^ (fast & rx_key);
	wire rx_hit = (rx_nrz != rx_key); // idle descrambles to one

	// lock needs a run of correctly predicted idle bits
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_match_r <= 7'h0;
			rx_lock_r <= 1'b0;
		end else if (!rx_act_r || !fast) begin
			rx_match_r <= 7'h0;
			rx_lock_r <= 1'b0;
		end else if (!rx_lock_r) begin
			rx_match_r <= rx_hit ? rx_match_r + 7'h1 : 7'h0;
			rx_lock_r <= rx_hit && (rx_match_r == fpc_pkg::LOCK_MATCHES - 7'h1);
		end
	end
	assign RX_LOCKED = rx_lock_r;

	// ****************************************
	// receive: alignment, decode, nibble out
	// ****************************************
	logic [9:0] rx_sh_r;
	logic [2:0] rx_bit_r;
	logic rx_algn_r, rx_dv_r, rx_er_r, rx_vld_r;
	logic [3:0] rxd_r;
	wire rx_go = rx_act_r && (rx_lock_r || !fast);
	wire [9:0] rx_sh_nxt = {rx_sh_r[8:0], rx_desc};
	wire [4:0] rx_dec = fpc_pkg::dec5b4b(rx_sh_nxt[4:0]);
	wire rx_ssd = !rx_algn_r && (rx_sh_nxt == fpc_pkg::SYM_JK);
	wire rx_grp = rx_algn_r && (rx_bit_r == fpc_pkg::GRP_LAST);
	wire rx_end = rx_grp && (rx_sh_nxt[4:0] == fpc_pkg::SYM_T);
	wire rx_idle = rx_grp && (rx_sh_nxt[4:0] == fpc_pkg::SYM_IDLE);

	// groups counted from J K; T or early idle ends the frame
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_sh_r <= 10'h000;
			rx_bit_r <= 3'h0;
			{rx_algn_r, rx_dv_r, rx_er_r, rx_vld_r} <= 4'h0;
			rxd_r <= 4'h0;
		end else begin
			rx_sh_r <= rx_go ? rx_sh_nxt : 10'h000;
			rx_bit_r <= (rx_ssd || rx_grp) ? 3'h0 : rx_bit_r + 3'h1;
			rx_algn_r <= rx_go && (rx_ssd || (rx_algn_r && !rx_end && !rx_idle));
			rx_dv_r <= rx_go && (rx_ssd || (rx_dv_r && !rx_end && !rx_idle));
			rx_vld_r <= rx_go && (rx_ssd || (rx_grp && !rx_end && !rx_idle));
			rx_er_r <= rx_go && (rx_idle || (rx_grp && !rx_end && !rx_dec[4]));
			if (rx_ssd) begin
				rxd_r <= fpc_pkg::NIB_PREAMBLE;
			end else if (rx_grp) begin
				rxd_r <= rx_dec[3:0];
			end
		end
	end
	assign RXD = rxd_r;
	assign RX_DV = rx_dv_r;
	assign RX_ER = rx_er_r;
	assign RX_VALID = rx_vld_r;

	// ****************************************
	// checks
	// ****************************************
	a_tx_pop_boundary: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		tx_pop |-> tx_bit_r == 3'h4 && $past(tx_bit_r, 4) == 3'h0)
		else $error("fifo popped away from a group boundary");
	a_tx_frame_start: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(tx_bound && tx_st_r == fpc_pkg::TX_IDLE && q_en) |=>
			tx_sh_r == fpc_pkg::SYM_J ##5 tx_sh_r == fpc_pkg::SYM_K)
		else $error("frame did not open with J then K");
	a_tx_mlt_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		!tx_scr_bit |-> ##2 tx_mlt_r == $past(tx_mlt_r))
		else $error("mlt3 moved on a zero bit");
	a_tx_mlt_step: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		tx_scr_bit |-> ##2 tx_mlt_r == $past(tx_mlt_r) + 2'h1)
		else $error("mlt3 held on a one bit");
	a_tx_slow_bypass: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		!fast |-> tx_scr_bit == tx_code_bit)
		else $error("scrambler active at 10 Mbit/s");
	a_rx_nrzi_toggle: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		rx_chg |=> rx_nrzi_r != $past(rx_nrzi_r))
		else $error("nrzi missed an mlt3 level change");
	a_rx_nrz_bit: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		rx_chg |=> rx_nrz)
		else $error("level change not decoded as a one");
	a_rx_desc_path: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		(fast && rx_lock_r) |-> rx_desc == (rx_nrz ^ rx_key))
		else $error("locked path not descrambled");
	a_rx_lock_run: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		$rose(rx_lock_r) |-> $past(rx_match_r) == fpc_pkg::LOCK_MATCHES - 7'h1)
		else $error("lock without a full run of matches");
	a_rx_valid_in_frame: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		rx_vld_r |-> rx_dv_r)
		else $error("nibble strobed outside a frame");
endmodule

// ---- verification/fpc_mac_model.sv ----
// mac model: feeds queued nibbles to the transmit port as ready allows
`timescale 1ns/10ps
module fpc_mac_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tx_ready,
	input wire logic slow,
	output logic [3:0] txd,
	output logic tx_en,
	output logic tx_er,
	output logic busy
);
	logic [4:0] q[$];
	logic took = 1'b0;

	// ****************************************
	// queue filled by the bench
	// ****************************************
	task automatic send(input logic er, input logic [3:0] n);
		q.push_back({er, n});
	endtask

	initial begin
		txd = 4'h0;
		tx_en = 1'b0;
		tx_er = 1'b0;
		busy = 1'b0;
	end

	// a nibble counts as taken only at an edge with ready high
	always @(posedge clk) took <= tx_en & tx_ready & rst_n;

	// drive after the falling edge; head stays until taken
	always @(negedge clk) begin
		if (took && q.size() != 0) begin
			q.delete(0);
		end
		if (rst_n && q.size() != 0 && !(slow && $urandom_range(3) == 0)) begin
			txd <= q[0][3:0];
			tx_er <= q[0][4];
			tx_en <= 1'b1;
		end else begin
			txd <= ~txd; // no stale data when idle
			tx_er <= 1'b0;
			tx_en <= 1'b0;
		end
		busy <= (q.size() != 0);
	end
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench: line loopback of the coding path with a mac model
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic spd = 1'b1;
	logic rxp = 1'b0;
	logic rxn = 1'b0;
	logic loop_on = 1'b0;
	logic slow = 1'b0;
	logic cap = 1'b0;
	logic dv_seen = 1'b0;
	logic full_seen = 1'b0;
	logic [1:0] lvl_p = 2'h0;
	logic [1:0] last_nz = 2'h1;
	logic [3:0] txd;
	logic tx_en;
	logic tx_er;
	logic busy;
	logic tx_ready;
	logic txp;
	logic txn;
	logic [3:0] rxd;
	logic rx_dv;
	logic rx_er;
	logic rx_valid;
	logic rx_locked;
	logic bq[$];
	logic [4:0] rxq[$];
	int failures = 0;
	int total_checks = 0;
	int mlt_bad = 0;
	int cycles = 0;
	wire logic [1:0] lvl = {txp, txn};

	always #50 clk = ~clk;

	fpc_top fpc_top_i (.REF_CLK(clk), .RESETN(rst_n), .SPEED_100(spd), .TXD(txd),
		.TX_EN(tx_en), .TX_ER(tx_er), .TX_READY(tx_ready), .TX_MLT3_P(txp),
		.TX_MLT3_N(txn), .RX_MLT3_P(rxp), .RX_MLT3_N(rxn), .RXD(rxd), .RX_DV(rx_dv),
		.RX_ER(rx_er), .RX_VALID(rx_valid), .RX_LOCKED(rx_locked));

	fpc_mac_model fpc_mac_model_i (.clk(clk), .rst_n(rst_n), .tx_ready(tx_ready),
		.slow(slow), .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .busy(busy));

	// ****************************************
	// compare and verdict
	// ****************************************
	task automatic chk1(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk5(input string what, input logic [4:0] exp, input logic [4:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// hang guard, far above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// ****************************************
	// loopback and line monitor
	// ****************************************
	// one transition of the line level is one line bit of value 1
	always @(negedge clk) begin
		rxp <= loop_on & txp;
		rxn <= loop_on & txn;
		if (!rst_n) begin
			last_nz = 2'h1;
		end else begin
			if (txp & txn) begin
				mlt_bad++;
			end
			if (lvl != lvl_p && lvl != 2'h0) begin
				if (lvl_p != 2'h0 || lvl == last_nz) begin
					mlt_bad++;
				end
				last_nz = lvl;
			end
			if (cap) begin
				bq.push_back(lvl != lvl_p);
			end
			if (rx_valid === 1'b1) begin
				rxq.push_back({rx_er, rxd});
			end
			if (rx_dv === 1'b1) begin
				dv_seen = 1'b1;
			end
			if (tx_ready === 1'b0) begin
				full_seen = 1'b1;
			end
		end
		lvl_p = lvl;
	end

	// ****************************************
	// expectations and sequences
	// ****************************************
	// key is the inverse of idle line bits; x^11+x^9+1, never all zero
	function automatic int key_errs(input logic scr);
		int e = 0;
		int zeros = 0;
		for (int i = 0; i < bq.size(); i++) begin
			zeros += (bq[i] == 1'b0);
			if (!scr && bq[i] !== 1'b1) e++;
			if (scr && i >= 11 && (~bq[i]) !== (bq[i-11] ^ bq[i-9])) e++;
			if (scr && i >= 2047 && bq[i] !== bq[i-2047]) e++;
		end
		return e + int'(scr && zeros == 0);
	endfunction

	task automatic capture(input int n);
		bq.delete();
		cap = 1'b1;
		repeat (n) @(negedge clk);
		cap = 1'b0;
	endtask

	task automatic wait_lock();
		for (int w = 0; w < 600 && rx_locked !== 1'b1; w++) @(negedge clk);
		chk1("locked", 1'b1, rx_locked);
	endtask

	task automatic reset_chk();
		chk1("ready in reset", 1'b1, tx_ready);
		chk1("line zero in reset", 1'b0, txp | txn);
		chk1("rx quiet in reset", 1'b0, rx_dv | rx_valid | rx_er | rx_locked);
	endtask

	// first two nibbles become the delimiter, seen back as one preamble nibble
	task automatic run_frame(input int len, input int er_at);
		logic [4:0] exp[$];
		logic [3:0] n;
		rxq.delete();
		dv_seen = 1'b0;
		exp.push_back(5'h05);
		for (int k = 0; k < len; k++) begin
			n = (k < 2) ? 4'h5 : 4'($urandom);
			fpc_mac_model_i.send(k >= 2 && k == er_at, n);
			if (k >= 2) exp.push_back((k == er_at) ? 5'h10 : {1'b0, n});
		end
		for (int w = 0; w < len * 8 + 300 && !(dv_seen && rx_dv === 1'b0); w++) @(negedge clk);
		chk1("rx nibble count", 1'b1, rxq.size() == exp.size());
		for (int k = 0; k < exp.size() && k < rxq.size(); k++) begin
			chk5("rx nibble", exp[k], rxq[k]);
		end
		chk1("mac queue drained", 1'b0, busy);
	endtask

	initial begin
		void'($urandom(32'h4288B1EF));
		repeat (4) @(negedge clk);
		reset_chk();
		rst_n = 1'b1;
		loop_on = 1'b1;
		wait_lock();
		capture(2100);
		chk1("scrambler key", 1'b1, key_errs(1'b1) == 0);
		run_frame(3, -1);
		run_frame(24, -1);
		chk1("fifo full seen", 1'b1, full_seen);
		run_frame(12, 5);
		slow = 1'b1;
		for (int f = 0; f < 6; f++) begin
			run_frame(3 + int'($urandom % 20), int'($urandom % 30));
		end
		slow = 1'b0;
		loop_on = 1'b0;
		repeat (200) @(negedge clk);
		chk1("lock lost when quiet", 1'b0, rx_locked);
		loop_on = 1'b1;
		wait_lock();
		spd = 1'b0;
		repeat (20) @(negedge clk);
		chk1("no lock at 10", 1'b0, rx_locked);
		capture(200);
		chk1("unscrambled idle", 1'b1, key_errs(1'b0) == 0);
		run_frame(10, 4);
		rst_n = 1'b0;
		spd = 1'b1;
		@(negedge clk);
		reset_chk();
		rst_n = 1'b1;
		wait_lock();
		run_frame(8, -1);
		chk1("mlt3 step order", 1'b1, mlt_bad == 0);
		print_verdict();
	end
endmodule
